// ==== design/smr_pkg.sv ====
// Package: constants, field layouts and types for slow mode and reset control
package smr_pkg;
   // Fast clock rate; the stretch and pin figures are counted in its periods
   localparam int unsigned HF_CLOCK_FREQ_HZ = 20_000_000;
   localparam int unsigned STRETCH_FC_PERIODS = 24;
   localparam logic [4:0] STRETCH_CYCLES = 5'(STRETCH_FC_PERIODS);
   localparam int unsigned EXT_RST_MIN_FC_PERIODS = 12;
   // Low-frequency edges seen before the clock hands back to fast
   localparam logic [1:0] LF_SYNC_EDGES = 2'h2;
   // Field positions in system_control_two
   localparam int unsigned SC2_HF_EN_BIT = 7;
   localparam int unsigned SC2_LF_EN_BIT = 6;
   localparam int unsigned SC2_SEL_BIT = 5;
   // Start-up vector locations
   localparam logic [15:0] VEC_ADDR_LO = 16'hfffe;
   localparam logic [15:0] VEC_ADDR_HI = 16'hffff;
   // Trap areas
   localparam logic [15:0] SFR_FIRST = 16'h0000;
   localparam logic [15:0] SFR_LAST = 16'h003f;
   localparam logic [15:0] RAM_FIRST = 16'h0040;
   localparam logic [15:0] RAM_LAST = 16'h023f;
   // Latch position for the trap interrupt
   localparam int unsigned IL_TRAP_BIT = 2;
   localparam int unsigned IRQ_W = 16;
   localparam int unsigned PRESC_W = 8;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_ZERO = 16'h0000;

   // Oscillator and clock select bits of system_control_two
   typedef struct packed {
      logic hf_en;
      logic lf_en;
      logic sel_slow;
   } smr_sc2_s;

   localparam smr_sc2_s SC2_RESET = '{hf_en: 1'b1, lf_en: 1'b0, sel_slow: 1'b0};

   // Operating modes
   typedef enum logic [3:0] {
      FAST_SINGLE_CLOCK_MODE = 4'h1,
      FAST_DUAL_CLOCK_MODE = 4'h2,
      SLOW_DUAL_OSC_MODE = 4'h4,
      SLOW_ONLY_MODE = 4'h8
   } smr_mode_e;

   // Vector fetch sequence after reset
   typedef enum logic [3:0] {
      VF_HOLD = 4'h1,
      VF_LO = 4'h2,
      VF_HI = 4'h4,
      VF_RUN = 4'h8
   } smr_vf_e;
endpackage

// ==== design/smr_sync.sv ====
// Two-stage synchroniser for a pin that is asynchronous to sys_clk
`timescale 1ns/1ps
module smr_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Pin and its synchronised copy
   input wire logic pin_in,
   output logic pin_sync_r
);
   logic meta_r;

   // First stage is read only by the second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         pin_sync_r <= RST_VAL;
      end else begin
         meta_r <= pin_in;
         pin_sync_r <= meta_r;
      end
   end
endmodule

// ==== design/smr_stretch.sv ====
// Malfunction reset stretch counter on the fast clock
`timescale 1ns/1ps
module smr_stretch
   import smr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Request and stretched result
   input wire logic malf_req,
   output logic busy
);
   logic [4:0] cnt_r;

   // Counter starts loaded: no clean power-up state, so a bounded stretch
   // is expected right after power-on
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= STRETCH_CYCLES;
      end else if (malf_req) begin
         cnt_r <= STRETCH_CYCLES;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end

   assign busy = (cnt_r != 5'h00);
endmodule

// ==== design/smr_top.sv ====
// Slow mode switching and reset merge with start-up vector fetch
`timescale 1ns/1ps
module smr_top
   import smr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Pins from outside the clock domain
   input wire logic reset_pin_n,
   input wire logic lf_clk_pin,
   // system_control_two write
   input wire logic sc2_wr,
   input wire logic [7:0] sc2_wdata,
   // Instruction fetch watch and trap setup
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic trap_ram_area_select,
   input wire logic trap_to_irq,
   // Watchdog
   input wire logic wdog_reset_req,
   input wire logic wdog_disable_wr,
   // Interrupt state writes and request sets
   input wire logic imf_wr,
   input wire logic imf_wdata,
   input wire logic ef_wr,
   input wire logic [IRQ_W-1:0] ef_wdata,
   input wire logic il_wr,
   input wire logic [IRQ_W-1:0] il_wdata,
   input wire logic [IRQ_W-1:0] irq_set,
   // Vector memory read data
   input wire logic [7:0] vec_rd_data,
   // Clock and mode state
   output smr_sc2_s sc2_r,
   output logic sys_on_slow_r,
   output smr_mode_e mode_r,
   // Reset state
   output logic int_reset_r,
   // Vector fetch
   output logic vec_rd_r,
   output logic [15:0] vec_addr_r,
   output logic [15:0] pc_r,
   output logic pc_valid_r,
   // Interrupt and timing state
   output logic irq_master_enable_r,
   output logic [IRQ_W-1:0] irq_individual_enable_r,
   output logic [IRQ_W-1:0] irq_request_latch_r,
   output logic [PRESC_W-1:0] tg_prescaler_r,
   output logic wdog_enable_r
);
   logic pin_n_sync;
   logic lf_sync;
   logic lf_prev_r;
   logic lf_edge;
   logic [1:0] lf_cnt_r;
   smr_sc2_s wd;
   logic sysclk_rst;
   logic trap_hit;
   logic trap_rst;
   logic trap_irq;
   logic malf_req;
   logic stretch_busy;
   smr_vf_e vf_r;

   // True when an address lies in an inclusive window
   function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction

   // Pins pass two flops; the pin idles high so it resets high
   smr_sync #(.RST_VAL(1'b1)) u_pin_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(reset_pin_n),
      .pin_sync_r(pin_n_sync)
   );

   smr_sync #(.RST_VAL(1'b0)) u_lf_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in(lf_clk_pin),
      .pin_sync_r(lf_sync)
   );

   // Write data split into the three control fields
   assign wd.hf_en = sc2_wdata[SC2_HF_EN_BIT];
   assign wd.lf_en = sc2_wdata[SC2_LF_EN_BIT];
   assign wd.sel_slow = sc2_wdata[SC2_SEL_BIT];

   // Illegal clock setup detection, judged against the current select
   assign sysclk_rst = sc2_wr && !int_reset_r &&
                       ((!wd.hf_en && !wd.lf_en) ||
                        (!wd.hf_en && !sc2_r.sel_slow) ||
                        (!wd.lf_en && sc2_r.sel_slow));

   // Trap decode: SFR area always, RAM only when selected
   assign trap_hit = fetch_valid && !int_reset_r &&
                     (in_win(fetch_addr, SFR_FIRST, SFR_LAST) ||
                      (trap_ram_area_select &&
                       in_win(fetch_addr, RAM_FIRST, RAM_LAST)));
   assign trap_rst = trap_hit && !trap_to_irq;
   assign trap_irq = trap_hit && trap_to_irq;

   // All malfunction sources share one stretch
   assign malf_req = trap_rst || wdog_reset_req || sysclk_rst;

   smr_stretch u_stretch (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .malf_req(malf_req),
      .busy(stretch_busy)
   );

   // Internal reset: pin low or stretch running
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_reset_r <= 1'b1;
      end else begin
         int_reset_r <= !pin_n_sync || stretch_busy;
      end
   end

   // system_control_two; a clock reset write is dropped so oscillators run on
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sc2_r <= SC2_RESET;
      end else if (!pin_n_sync) begin
         sc2_r <= SC2_RESET;
      end else if (int_reset_r) begin
         sc2_r.hf_en <= 1'b1;
         sc2_r.sel_slow <= 1'b0;
      end else if (sc2_wr && !sysclk_rst) begin
         sc2_r <= wd;
      end
   end

   // Low-frequency edge detect reads only the second sync stage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lf_prev_r <= 1'b0;
      end else begin
         lf_prev_r <= lf_sync;
      end
   end

   assign lf_edge = lf_sync && !lf_prev_r;

   // Clock changeover: into slow at once, back to fast only after sync edges
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_on_slow_r <= 1'b0;
         lf_cnt_r <= 2'h0;
      end else if (int_reset_r) begin
         sys_on_slow_r <= 1'b0;
         lf_cnt_r <= 2'h0;
      end else if (sc2_r.sel_slow) begin
         sys_on_slow_r <= 1'b1;
         lf_cnt_r <= 2'h0;
      end else if (sys_on_slow_r && lf_edge) begin
         if (lf_cnt_r == LF_SYNC_EDGES - 2'h1) begin
            sys_on_slow_r <= 1'b0;
            lf_cnt_r <= 2'h0;
         end else begin
            lf_cnt_r <= lf_cnt_r + 2'h1;
         end
      end
   end

   // Reported mode follows the clock in use and the oscillators
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= FAST_SINGLE_CLOCK_MODE;
      end else if (sys_on_slow_r) begin
         mode_r <= sc2_r.hf_en ? SLOW_DUAL_OSC_MODE : SLOW_ONLY_MODE;
      end else begin
         mode_r <= sc2_r.lf_en ? FAST_DUAL_CLOCK_MODE : FAST_SINGLE_CLOCK_MODE;
      end
   end

   // Vector fetch: memory must present data in the cycle the read stands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         vf_r <= VF_HOLD;
         vec_rd_r <= 1'b0;
         vec_addr_r <= VEC_ADDR_LO;
         pc_r <= 16'h0000;
         pc_valid_r <= 1'b0;
      end else if (int_reset_r) begin
         vf_r <= VF_HOLD;
         vec_rd_r <= 1'b0;
         vec_addr_r <= VEC_ADDR_LO;
         pc_valid_r <= 1'b0;
      end else begin
         case (vf_r)
            VF_HOLD: begin
               vf_r <= VF_LO;
               vec_rd_r <= 1'b1;
               vec_addr_r <= VEC_ADDR_LO;
            end
            VF_LO: begin
               vf_r <= VF_HI;
               pc_r[7:0] <= vec_rd_data;
               vec_addr_r <= VEC_ADDR_HI;
            end
            VF_HI: begin
               vf_r <= VF_RUN;
               pc_r[15:8] <= vec_rd_data;
               vec_rd_r <= 1'b0;
               pc_valid_r <= 1'b1;
            end
            VF_RUN: begin
               vf_r <= VF_RUN;
            end
            default: begin
               vf_r <= VF_HOLD;
            end
         endcase
      end
   end

   // Interrupt master and individual enables
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_master_enable_r <= 1'b0;
         irq_individual_enable_r <= IRQ_ZERO;
      end else if (int_reset_r) begin
         irq_master_enable_r <= 1'b0;
         irq_individual_enable_r <= IRQ_ZERO;
      end else begin
         if (imf_wr) begin
            irq_master_enable_r <= imf_wdata;
         end
         if (ef_wr) begin
            irq_individual_enable_r <= ef_wdata;
         end
      end
   end

   // Request latches: a set in the clearing cycle survives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_request_latch_r <= IRQ_ZERO;
      end else if (int_reset_r) begin
         irq_request_latch_r <= IRQ_ZERO;
      end else begin
         irq_request_latch_r <= ((il_wr ? il_wdata : irq_request_latch_r) | irq_set) |
                                (IRQ_W'(trap_irq) << IL_TRAP_BIT);
      end
   end

   // Timing generator prescaler runs free outside reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tg_prescaler_r <= PRESC_ZERO;
      end else if (int_reset_r) begin
         tg_prescaler_r <= PRESC_ZERO;
      end else begin
         tg_prescaler_r <= tg_prescaler_r + 8'h01;
      end
   end

   // Watchdog enable: set by reset, dropped by software
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_enable_r <= 1'b1;
      end else if (int_reset_r) begin
         wdog_enable_r <= 1'b1;
      end else if (wdog_disable_wr) begin
         wdog_enable_r <= 1'b0;
      end
   end

   // Checks
   sequence s_vec_lo;
      vec_rd_r && (vec_addr_r == VEC_ADDR_LO);
   endsequence

   sequence s_vec_hi;
      vec_rd_r && (vec_addr_r == VEC_ADDR_HI);
   endsequence

   property p_slow_enter;
      @(posedge sys_clk) disable iff (!rst_n)
      sc2_r.sel_slow && !int_reset_r |=> sys_on_slow_r;
   endproperty
   a_slow_enter: assert property (p_slow_enter) else $error("slow select not taken");

   property p_hf_off;
      @(posedge sys_clk) disable iff (!rst_n)
      sc2_wr && !sysclk_rst && !wd.hf_en && pin_n_sync && !int_reset_r |=> !sc2_r.hf_en;
   endproperty
   a_hf_off: assert property (p_hf_off) else $error("fast oscillator not stopped");

   property p_fast_wait;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(sc2_r.sel_slow) && sys_on_slow_r && !int_reset_r |-> sys_on_slow_r[*3];
   endproperty
   a_fast_wait: assert property (p_fast_wait) else $error("left slow clock too soon");

   property p_pin_restart;
      @(posedge sys_clk) disable iff (!rst_n)
      !pin_n_sync |=> int_reset_r ##1 (sc2_r == SC2_RESET) && !sys_on_slow_r;
   endproperty
   a_pin_restart: assert property (p_pin_restart) else $error("pin reset mode wrong");

   property p_malf_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      malf_req |-> ##2 int_reset_r[*8];
   endproperty
   a_malf_hold: assert property (p_malf_hold) else $error("malfunction reset short");

   property p_init;
      @(posedge sys_clk) disable iff (!rst_n)
      int_reset_r |=> !irq_master_enable_r && (irq_individual_enable_r == IRQ_ZERO) &&
                      (irq_request_latch_r == IRQ_ZERO) && wdog_enable_r &&
                      (tg_prescaler_r == PRESC_ZERO);
   endproperty
   a_init: assert property (p_init) else $error("reset state not initialised");

   property p_vector;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(int_reset_r) |=> s_vec_lo ##1 s_vec_hi ##1 pc_valid_r && !vec_rd_r;
   endproperty
   a_vector: assert property (p_vector) else $error("vector fetch order wrong");

   property p_trap_rst;
      @(posedge sys_clk) disable iff (!rst_n)
      trap_hit && !trap_to_irq |-> ##2 int_reset_r;
   endproperty
   a_trap_rst: assert property (p_trap_rst) else $error("trap reset missing");

   property p_trap_irq;
      @(posedge sys_clk) disable iff (!rst_n)
      trap_hit && trap_to_irq && !malf_req && pin_n_sync && !stretch_busy
         |=> irq_request_latch_r[IL_TRAP_BIT] && !int_reset_r;
   endproperty
   a_trap_irq: assert property (p_trap_irq) else $error("trap interrupt missing");

   property p_clk_rst;
      @(posedge sys_clk) disable iff (!rst_n)
      sysclk_rst |=> (sc2_r == $past(sc2_r)) ##1 int_reset_r;
   endproperty
   a_clk_rst: assert property (p_clk_rst) else $error("clock reset mishandled");
endmodule

// ==== verif/smr_partner.sv ====
// Far-side model: reset pin source, slow oscillator pin and vector memory
`timescale 1ns/1ps
module smr_partner
   import smr_pkg::*;
#(
   parameter logic [7:0] VEC_LO = 8'h34,
   parameter logic [7:0] VEC_HI = 8'h12,
   parameter int PIN_LOW = 12
) (
   // Clock
   input wire logic sys_clk,
   // Scenario control from the bench
   input wire logic pin_go,
   // Vector read port
   input wire logic vec_rd_r,
   input wire logic [15:0] vec_addr_r,
   output logic [7:0] vec_rd_data,
   // Pins
   output logic reset_pin_n,
   output logic lf_clk_pin
);
   int pin_cnt = 0;
   logic [7:0] idle_pat = 8'h5a;

   // Slow crystal runs free, phase unrelated to sys_clk
   initial begin
      lf_clk_pin = 1'b0;
      forever #170 lf_clk_pin = ~lf_clk_pin;
   end

   // Pin held low for the full minimum span once asked
   always @(posedge sys_clk) begin
      if (pin_go) begin
         pin_cnt <= PIN_LOW;
      end else if (pin_cnt > 0) begin
         pin_cnt <= pin_cnt - 1;
      end
   end
   assign reset_pin_n = (pin_cnt == 0);

   // Unaddressed bus shows a changing pattern, never the last byte
   always @(posedge sys_clk) begin
      idle_pat <= ~idle_pat;
   end
   assign vec_rd_data = !vec_rd_r ? idle_pat :
                        (vec_addr_r == VEC_ADDR_LO) ? VEC_LO :
                        (vec_addr_r == VEC_ADDR_HI) ? VEC_HI : ~idle_pat;
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for slow mode switching and reset merge
`timescale 1ns/1ps
module testbench
   import smr_pkg::*;
;
   localparam logic [15:0] EXP_PC = 16'h1234;
   logic sys_clk, rst_n, sc2_wr, fetch_valid, trap_ram_area_select, trap_to_irq;
   logic wdog_reset_req, wdog_disable_wr, imf_wr, imf_wdata, ef_wr, il_wr, pin_go;
   logic [7:0] sc2_wdata;
   logic [15:0] fetch_addr;
   logic [IRQ_W-1:0] ef_wdata, il_wdata, irq_set;
   logic reset_pin_n, lf_clk_pin, sys_on_slow_r, int_reset_r, vec_rd_r, pc_valid_r;
   logic [7:0] vec_rd_data;
   logic [15:0] vec_addr_r, pc_r;
   smr_sc2_s sc2_r;
   smr_mode_e mode_r;
   logic irq_master_enable_r, wdog_enable_r;
   logic [IRQ_W-1:0] irq_individual_enable_r, irq_request_latch_r;
   logic [PRESC_W-1:0] tg_prescaler_r;
   int num_errors = 0;
   int check_count = 0;

   // Design and its far side
   smr_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
      .lf_clk_pin(lf_clk_pin), .sc2_wr(sc2_wr), .sc2_wdata(sc2_wdata),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .trap_ram_area_select(trap_ram_area_select), .trap_to_irq(trap_to_irq),
      .wdog_reset_req(wdog_reset_req), .wdog_disable_wr(wdog_disable_wr),
      .imf_wr(imf_wr), .imf_wdata(imf_wdata), .ef_wr(ef_wr), .ef_wdata(ef_wdata),
      .il_wr(il_wr), .il_wdata(il_wdata), .irq_set(irq_set), .vec_rd_data(vec_rd_data),
      .sc2_r(sc2_r), .sys_on_slow_r(sys_on_slow_r), .mode_r(mode_r),
      .int_reset_r(int_reset_r), .vec_rd_r(vec_rd_r), .vec_addr_r(vec_addr_r),
      .pc_r(pc_r), .pc_valid_r(pc_valid_r), .irq_master_enable_r(irq_master_enable_r),
      .irq_individual_enable_r(irq_individual_enable_r),
      .irq_request_latch_r(irq_request_latch_r), .tg_prescaler_r(tg_prescaler_r),
      .wdog_enable_r(wdog_enable_r));
   smr_partner #(.VEC_LO(EXP_PC[7:0]), .VEC_HI(EXP_PC[15:8]), .PIN_LOW(12)) u_far (
      .sys_clk(sys_clk), .pin_go(pin_go), .vec_rd_r(vec_rd_r), .vec_addr_r(vec_addr_r),
      .vec_rd_data(vec_rd_data), .reset_pin_n(reset_pin_n), .lf_clk_pin(lf_clk_pin));

   // Clock, 50 ns period
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Sample just after the edge so register updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr_sc2(input logic [7:0] d);
      @(posedge sys_clk);
      sc2_wr <= 1'b1;
      sc2_wdata <= d;
      @(posedge sys_clk);
      sc2_wr <= 1'b0;
      #1;
   endtask

   // Waits a few cycles for a reset to start, then counts its length
   task automatic rst_len(output int n);
      int w;
      n = 0;
      w = 0;
      while (int_reset_r !== 1'b1 && w < 8) begin
         tick(1);
         w++;
      end
      while (int_reset_r === 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
   endtask

   task automatic vec_chk();
      tick(4);
      chk("pc", EXP_PC, pc_r);
      chk("pc_valid", 16'h1, 16'(pc_valid_r));
      chk("vec_rd", 16'h0, 16'(vec_rd_r));
      chk("vec_addr", VEC_ADDR_HI, vec_addr_r);
   endtask

   task automatic rst_state();
      chk("imf", 16'h0, 16'(irq_master_enable_r));
      chk("ef", IRQ_ZERO, irq_individual_enable_r);
      chk("il", IRQ_ZERO, irq_request_latch_r);
      chk("presc", 16'(PRESC_ZERO), 16'(tg_prescaler_r));
      chk("wdog_en", 16'h1, 16'(wdog_enable_r));
   endtask

   task automatic t_power();
      int n;
      rst_len(n);
      chk("powerup stretch", 16'h1, 16'(n <= 27));
      chk("sc2", 16'(SC2_RESET), 16'(sc2_r));
      chk("mode", 16'(FAST_SINGLE_CLOCK_MODE), 16'(mode_r));
      rst_state();
      vec_chk();
      $display("t_power done, errors %0d", num_errors);
   endtask

   task automatic t_slow();
      int w;
      wr_sc2(8'hc0);
      wr_sc2(8'he0);
      tick(4);
      chk("slow", 16'h1, 16'(sys_on_slow_r));
      chk("mode", 16'(SLOW_DUAL_OSC_MODE), 16'(mode_r));
      wr_sc2(8'h60); // Fast osc off, as needed before any stop
      tick(3);
      chk("hf_en", 16'h0, 16'(sc2_r.hf_en));
      chk("mode", 16'(SLOW_ONLY_MODE), 16'(mode_r));
      wr_sc2(8'he0); // Fast osc first, then warm-up
      tick(20);
      wr_sc2(8'hc0);
      tick(2);
      chk("still slow", 16'h1, 16'(sys_on_slow_r));
      w = 0;
      while (sys_on_slow_r === 1'b1 && w < 60) begin
         tick(1);
         w++;
      end
      tick(2);
      chk("fast", 16'h0, 16'(sys_on_slow_r));
      chk("mode", 16'(FAST_DUAL_CLOCK_MODE), 16'(mode_r));
      chk("no reset", 16'h0, 16'(int_reset_r));
      $display("t_slow done, errors %0d", num_errors);
   endtask

   // Two illegal oscillator settings from fast and two from slow
   task automatic t_clkrst();
      logic [7:0] pre [4] = '{8'hc0, 8'hc0, 8'he0, 8'he0};
      logic [7:0] bad [4] = '{8'h40, 8'h00, 8'ha0, 8'h20};
      int n;
      for (int i = 0; i < 4; i++) begin
         wr_sc2(pre[i]);
         wr_sc2(bad[i]);
         rst_len(n);
         chk("clk rst len", 16'd24, 16'(n));
         chk("hf_en", 16'h1, 16'(sc2_r.hf_en));
         chk("lf_en", 16'h1, 16'(sc2_r.lf_en));
         vec_chk();
      end
      $display("t_clkrst done, errors %0d", num_errors);
   endtask

   task automatic trap_try(input logic [15:0] a, input int exp_n);
      int n;
      @(posedge sys_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      @(posedge sys_clk);
      fetch_valid <= 1'b0;
      #1;
      rst_len(n);
      chk("trap rst len", 16'(exp_n), 16'(n));
      tick(5);
   endtask

   task automatic t_trap();
      trap_try(16'h0100, 0);
      trap_try(16'h003f, 24);
      @(posedge sys_clk);
      trap_ram_area_select <= 1'b1;
      trap_try(16'h0040, 24);
      trap_try(16'h0240, 0);
      @(posedge sys_clk);
      trap_to_irq <= 1'b1;
      trap_try(16'h0000, 0);
      chk("trap latch", 16'h1, 16'(irq_request_latch_r[IL_TRAP_BIT]));
      $display("t_trap done, errors %0d", num_errors);
   endtask

   task automatic t_wdog();
      int n;
      @(posedge sys_clk);
      imf_wr <= 1'b1;
      imf_wdata <= 1'b1;
      ef_wr <= 1'b1;
      ef_wdata <= 16'hffff;
      irq_set <= 16'h0008;
      il_wr <= 1'b1;
      il_wdata <= IRQ_ZERO;
      wdog_disable_wr <= 1'b1;
      @(posedge sys_clk);
      imf_wr <= 1'b0;
      ef_wr <= 1'b0;
      irq_set <= IRQ_ZERO;
      il_wr <= 1'b0;
      wdog_disable_wr <= 1'b0;
      tick(2);
      chk("imf set", 16'h1, 16'(irq_master_enable_r));
      chk("ef set", 16'hffff, irq_individual_enable_r);
      // Load clears the old trap bit, the same-cycle request set still wins
      chk("il set wins", 16'h0008, irq_request_latch_r);
      chk("wdog off", 16'h0, 16'(wdog_enable_r));
      @(posedge sys_clk);
      wdog_reset_req <= 1'b1;
      @(posedge sys_clk);
      wdog_reset_req <= 1'b0;
      #1;
      rst_len(n);
      chk("wdog rst len", 16'd24, 16'(n));
      rst_state();
      vec_chk();
      $display("t_wdog done, errors %0d", num_errors);
   endtask

   task automatic t_pin();
      int w;
      wr_sc2(8'he0);
      tick(4);
      @(posedge sys_clk);
      pin_go <= 1'b1;
      @(posedge sys_clk);
      pin_go <= 1'b0;
      tick(8);
      chk("pin rst", 16'h1, 16'(int_reset_r));
      chk("sc2", 16'(SC2_RESET), 16'(sc2_r));
      w = 0;
      while (int_reset_r === 1'b1 && w < 60) begin
         tick(1);
         w++;
      end
      vec_chk();
      chk("slow", 16'h0, 16'(sys_on_slow_r));
      chk("mode", 16'(FAST_SINGLE_CLOCK_MODE), 16'(mode_r));
      $display("t_pin done, errors %0d", num_errors);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence; latch load is exercised once, against a request set
   initial begin
      rst_n = 1'b0;
      sc2_wr = 1'b0;
      sc2_wdata = 8'h00;
      fetch_valid = 1'b0;
      fetch_addr = 16'h0000;
      trap_ram_area_select = 1'b0;
      trap_to_irq = 1'b0;
      wdog_reset_req = 1'b0;
      wdog_disable_wr = 1'b0;
      imf_wr = 1'b0;
      imf_wdata = 1'b0;
      ef_wr = 1'b0;
      ef_wdata = IRQ_ZERO;
      il_wr = 1'b0;
      il_wdata = IRQ_ZERO;
      irq_set = IRQ_ZERO;
      pin_go = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_power();
      t_slow();
      t_clkrst();
      t_trap();
      t_wdog();
      t_pin();
      results();
   end

   // Tests need about 450 cycles; 20000 means a hang
   initial begin
      #1_000_000;
      num_errors++;
      results();
   end
endmodule
